/* File: hw/exc_seq_pkg.sv */
// Constants, codes and state encoding for the CPU exception sequencer
package exc_seq_pkg;

  localparam logic [1:0] MODE_0 = 2'h0;
  localparam logic [1:0] MODE_2 = 2'h2;

  localparam int CCR_MASK_BIT = 7;
  localparam int EXR_TRACE_BIT = 7;
  localparam int EXR_LEVEL_LSB = 0;
  localparam logic [2:0] LEVEL_ALL_MASKED = 3'h7;
  localparam logic [3:0] LEVEL_NMI = 4'h8;

  // Vector numbers; the interrupt controller supplies its own
  localparam logic [7:0] VEC_ADDR_ERR = 8'h09;
  localparam logic [7:0] VEC_ILLEGAL = 8'h04;
  localparam logic [7:0] VEC_SLOT_ILLEGAL = 8'h06;
  // Trap numbers sit clear of the fixed vectors so no two sources share an entry
  localparam logic [7:0] VEC_TRAP_BASE = 8'h0c;
  localparam logic [7:0] VEC_SLEEP = 8'h0a;
  localparam logic [31:0] VEC_ENTRY_BYTES = 32'h00000004;

  localparam logic [31:0] STACK_WORD_BYTES = 32'h00000004;

  localparam int SRC_NMI = 1;
  localparam int SRC_PINS = 12;
  localparam int SRC_DMA = 8;
  localparam int SRC_WATCHDOG = 1;
  localparam int SRC_CONVERTER = 1;
  localparam int SRC_PULSE_TIMER = 26;
  localparam int SRC_EIGHT_BIT_TIMER = 16;
  localparam int SRC_SERIAL = 24;
  localparam int SRC_TWO_WIRE = 2;
  localparam int SRC_USB = 5;
  localparam int SRC_TOTAL = SRC_NMI + SRC_PINS + SRC_DMA + SRC_WATCHDOG + SRC_CONVERTER
    + SRC_PULSE_TIMER + SRC_EIGHT_BIT_TIMER + SRC_SERIAL + SRC_TWO_WIRE + SRC_USB;

  localparam int DMA_CHANNELS = 4;

  typedef enum logic [3:0] {
    S_IDLE = 4'b0001,
    S_PUSH_PC = 4'b0010,
    S_PUSH_SR = 4'b0100,
    S_FETCH = 4'b1000
  } seq_state_t;

  typedef enum logic [1:0] {
    LVL_KEEP = 2'h0,
    LVL_SEVEN = 2'h1,
    LVL_INT = 2'h2
  } level_rule_t;

endpackage

/* File: hw/cpu_exception_sequencer.sv */
// Exception sequencer: stacking, vector fetch and status update for CPU exceptions
`timescale 1ns/1ns
`default_nettype none
module cpu_exception_sequencer #(
  parameter int CHANNELS = exc_seq_pkg::DMA_CHANNELS
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [1:0] mode_sel,
  input wire logic insn_boundary,
  input wire logic bus_busy,
  input wire logic cpu_has_bus,
  input wire logic [31:0] pc,
  input wire logic [7:0] condition_code_reg,
  input wire logic [7:0] extended_control_reg,
  input wire logic [31:0] sp,
  input wire logic [31:0] vector_base_reg,
  input wire logic addr_err,
  input wire logic trap_exec,
  input wire logic [1:0] trap_vec,
  input wire logic sleep_exec,
  input wire logic software_standby_select,
  input wire logic sleep_exception_enable,
  input wire logic undef_exec,
  input wire logic delay_slot,
  input wire logic slot_multiword,
  input wire logic slot_alters_pc,
  input wire logic int_req,
  input wire logic [3:0] int_level,
  input wire logic [7:0] int_vector,
  input wire logic mem_ack,
  input wire logic [31:0] mem_rdata,
  output logic busy,
  output logic int_ack,
  output logic mem_req,
  output logic mem_we,
  output logic [31:0] mem_addr,
  output logic [31:0] mem_wdata,
  output logic ctx_load,
  output logic [31:0] pc_new,
  output logic [7:0] ccr_new,
  output logic [7:0] exr_new,
  output logic [31:0] sp_new,
  output logic [7:0] exc_vector,
  output logic sleep_enter,
  output logic transfer_ctrl_err_set,
  output logic dma_error_flag_set,
  output logic [CHANNELS-1:0] dma_transfer_enable_clr
);

  if (CHANNELS < 1 || CHANNELS > 32)
  begin : g_channels_check
    $error("CHANNELS out of range");
  end

  // Mode field: anything but 10 is treated as mode 0, since other codes are prohibited
  logic mode2;
  assign mode2 = (mode_sel == exc_seq_pkg::MODE_2);

  // Pending exception flags
  logic ae_pend_q, ae_pend_d, ill_pend_q, ill_pend_d, slot_pend_q, slot_pend_d;
  logic trap_pend_q, trap_pend_d, slp_pend_q, slp_pend_d, sleep_enter_q, sleep_enter_d;
  logic [1:0] trap_num_q, trap_num_d;

  exc_seq_pkg::seq_state_t state_q, state_d;
  exc_seq_pkg::level_rule_t lvl_rule_q, lvl_rule_d;
  logic ae_seq_q, ae_seq_d, use_vbr_q, use_vbr_d, mode2_s_q, mode2_s_d;
  logic [7:0] vec_q, vec_d, ccr_s_q, ccr_s_d, exr_s_q, exr_s_d;
  logic [2:0] int_lvl_q, int_lvl_d;
  logic [31:0] sp_w_q, sp_w_d;

  // Registered outputs
  logic int_ack_q, int_ack_d, mem_req_q, mem_req_d, mem_we_q, mem_we_d, busy_q, busy_d;
  logic ctx_load_q, ctx_load_d, err_set_q, err_set_d;
  logic [31:0] mem_addr_q, mem_addr_d, mem_wdata_q, mem_wdata_d;
  logic [31:0] pc_new_q, pc_new_d, sp_new_q, sp_new_d;
  logic [7:0] ccr_new_q, ccr_new_d, exr_new_q, exr_new_d;

  logic at_boundary, take_ae, take_ill, take_slot, take_trap, take_slp, take_int, start;
  logic slot_bad, int_ok;
  logic [31:0] vec_addr;

  // Boundary only counts once the offending bus cycle is over
  assign at_boundary = (state_q == exc_seq_pkg::S_IDLE) && insn_boundary && !bus_busy;
  assign slot_bad = delay_slot && (slot_multiword || slot_alters_pc);

  assign int_ok = (int_level == exc_seq_pkg::LEVEL_NMI) ? 1'b1
    : mode2 ? ({1'b0, int_level[2:0]} > {1'b0, extended_control_reg[2:0]})
    : !condition_code_reg[exc_seq_pkg::CCR_MASK_BIT];

  // Fixed priority, one exception per boundary
  always_comb
  begin
    take_ae = at_boundary && ae_pend_q;
    take_ill = at_boundary && !ae_pend_q && ill_pend_q;
    take_slot = at_boundary && !ae_pend_q && !ill_pend_q && slot_pend_q;
    take_trap = at_boundary && !ae_pend_q && !ill_pend_q && !slot_pend_q && trap_pend_q;
    take_slp = at_boundary && !ae_pend_q && !ill_pend_q && !slot_pend_q && !trap_pend_q
      && slp_pend_q && cpu_has_bus;
    take_int = at_boundary && !ae_pend_q && !ill_pend_q && !slot_pend_q && !trap_pend_q
      && !(slp_pend_q && cpu_has_bus) && int_req && int_ok;
    start = take_ae || take_ill || take_slot || take_trap || take_slp || take_int;
  end

  // Pending capture; a new event in the take cycle wins over the clear, except an address error, which is dropped
  always_comb
  begin
    ae_pend_d = ae_pend_q && !take_ae;
    if (addr_err && !ae_seq_q && !take_ae)
      ae_pend_d = 1'b1;
    ill_pend_d = (ill_pend_q && !take_ill) || undef_exec;
    slot_pend_d = (slot_pend_q && !take_slot) || (slot_bad && !undef_exec);
    trap_pend_d = (trap_pend_q && !take_trap) || trap_exec;
    trap_num_d = trap_exec ? trap_vec : trap_num_q;
    sleep_enter_d = 1'b0;
    slp_pend_d = slp_pend_q && !take_slp;
    if (sleep_exec)
    begin
      if (!software_standby_select && sleep_exception_enable)
        slp_pend_d = 1'b1;
      else
        sleep_enter_d = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ae_pend_q <= 1'b0;
      ill_pend_q <= 1'b0;
      slot_pend_q <= 1'b0;
      trap_pend_q <= 1'b0;
      trap_num_q <= 2'h0;
      slp_pend_q <= 1'b0;
      sleep_enter_q <= 1'b0;
    end
    else
    begin
      ae_pend_q <= ae_pend_d;
      ill_pend_q <= ill_pend_d;
      slot_pend_q <= slot_pend_d;
      trap_pend_q <= trap_pend_d;
      trap_num_q <= trap_num_d;
      slp_pend_q <= slp_pend_d;
      sleep_enter_q <= sleep_enter_d;
    end
  end

  // Address error vectors are absolute, all others sit above the base register
  assign vec_addr = (use_vbr_q ? vector_base_reg : 32'h00000000)
    + ({24'h000000, vec_q} * exc_seq_pkg::VEC_ENTRY_BYTES);

  always_comb
  begin
    state_d = state_q;
    ae_seq_d = ae_seq_q;
    vec_d = vec_q;
    use_vbr_d = use_vbr_q;
    lvl_rule_d = lvl_rule_q;
    int_lvl_d = int_lvl_q;
    ccr_s_d = ccr_s_q;
    exr_s_d = exr_s_q;
    sp_w_d = sp_w_q;
    mode2_s_d = mode2_s_q;
    int_ack_d = 1'b0;
    mem_req_d = mem_req_q;
    mem_we_d = mem_we_q;
    mem_addr_d = mem_addr_q;
    mem_wdata_d = mem_wdata_q;
    ctx_load_d = 1'b0;
    pc_new_d = pc_new_q;
    ccr_new_d = ccr_new_q;
    exr_new_d = exr_new_q;
    sp_new_d = sp_new_q;
    err_set_d = 1'b0;
    unique case (state_q)
      exc_seq_pkg::S_IDLE:
      begin
        if (start)
        begin
          state_d = exc_seq_pkg::S_PUSH_PC;
          ae_seq_d = take_ae;
          err_set_d = take_ae;
          use_vbr_d = !take_ae;
          lvl_rule_d = exc_seq_pkg::LVL_KEEP;
          if (take_ae || take_slp)
            lvl_rule_d = exc_seq_pkg::LVL_SEVEN;
          else if (take_int)
            lvl_rule_d = exc_seq_pkg::LVL_INT;
          if (take_ae)
            vec_d = exc_seq_pkg::VEC_ADDR_ERR;
          else if (take_ill)
            vec_d = exc_seq_pkg::VEC_ILLEGAL;
          else if (take_slot)
            vec_d = exc_seq_pkg::VEC_SLOT_ILLEGAL;
          else if (take_trap)
            vec_d = exc_seq_pkg::VEC_TRAP_BASE + {6'h00, trap_num_q};
          else if (take_slp)
            vec_d = exc_seq_pkg::VEC_SLEEP;
          else
            vec_d = int_vector;
          int_ack_d = take_int;
          int_lvl_d = (int_level == exc_seq_pkg::LEVEL_NMI) ? exc_seq_pkg::LEVEL_ALL_MASKED
            : int_level[2:0];
          ccr_s_d = condition_code_reg;
          exr_s_d = extended_control_reg;
          mode2_s_d = mode2;
          // Odd stack pointer is not corrected; stacked data is then undefined
          sp_w_d = sp - exc_seq_pkg::STACK_WORD_BYTES;
          mem_req_d = 1'b1;
          mem_we_d = 1'b1;
          mem_addr_d = sp - exc_seq_pkg::STACK_WORD_BYTES;
          mem_wdata_d = pc;
        end
      end
      exc_seq_pkg::S_PUSH_PC:
      begin
        if (mem_ack)
        begin
          state_d = exc_seq_pkg::S_PUSH_SR;
          sp_w_d = sp_w_q - exc_seq_pkg::STACK_WORD_BYTES;
          mem_addr_d = sp_w_q - exc_seq_pkg::STACK_WORD_BYTES;
          mem_wdata_d = {16'h0000, ccr_s_q, exr_s_q};
        end
      end
      exc_seq_pkg::S_PUSH_SR:
      begin
        if (mem_ack)
        begin
          state_d = exc_seq_pkg::S_FETCH;
          mem_we_d = 1'b0;
          mem_addr_d = vec_addr;
          mem_wdata_d = 32'h00000000;
        end
      end
      exc_seq_pkg::S_FETCH:
      begin
        if (mem_ack)
        begin
          state_d = exc_seq_pkg::S_IDLE;
          ae_seq_d = 1'b0;
          mem_req_d = 1'b0;
          ctx_load_d = 1'b1;
          pc_new_d = mem_rdata;
          sp_new_d = sp_w_q;
          ccr_new_d = ccr_s_q;
          ccr_new_d[exc_seq_pkg::CCR_MASK_BIT] = 1'b1;
          exr_new_d = exr_s_q;
          // Trace and level belong to mode 2 only; mode 0 leaves the extended register alone
          if (mode2_s_q)
          begin
            exr_new_d[exc_seq_pkg::EXR_TRACE_BIT] = 1'b0;
            if (lvl_rule_q == exc_seq_pkg::LVL_SEVEN)
              exr_new_d[exc_seq_pkg::EXR_LEVEL_LSB +: 3] = exc_seq_pkg::LEVEL_ALL_MASKED;
            else if (lvl_rule_q == exc_seq_pkg::LVL_INT)
              exr_new_d[exc_seq_pkg::EXR_LEVEL_LSB +: 3] = int_lvl_q;
          end
        end
      end
    endcase
    busy_d = (state_d != exc_seq_pkg::S_IDLE);
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_q <= exc_seq_pkg::S_IDLE;
      ae_seq_q <= 1'b0;
      vec_q <= 8'h00;
      use_vbr_q <= 1'b0;
      lvl_rule_q <= exc_seq_pkg::LVL_KEEP;
      int_lvl_q <= 3'h0;
      ccr_s_q <= 8'h00;
      exr_s_q <= 8'h00;
      sp_w_q <= 32'h00000000;
      mode2_s_q <= 1'b0;
      int_ack_q <= 1'b0;
      mem_req_q <= 1'b0;
      mem_we_q <= 1'b0;
      mem_addr_q <= 32'h00000000;
      mem_wdata_q <= 32'h00000000;
      ctx_load_q <= 1'b0;
      pc_new_q <= 32'h00000000;
      ccr_new_q <= 8'h00;
      exr_new_q <= 8'h00;
      sp_new_q <= 32'h00000000;
      err_set_q <= 1'b0;
      busy_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      ae_seq_q <= ae_seq_d;
      vec_q <= vec_d;
      use_vbr_q <= use_vbr_d;
      lvl_rule_q <= lvl_rule_d;
      int_lvl_q <= int_lvl_d;
      ccr_s_q <= ccr_s_d;
      exr_s_q <= exr_s_d;
      sp_w_q <= sp_w_d;
      mode2_s_q <= mode2_s_d;
      int_ack_q <= int_ack_d;
      mem_req_q <= mem_req_d;
      mem_we_q <= mem_we_d;
      mem_addr_q <= mem_addr_d;
      mem_wdata_q <= mem_wdata_d;
      ctx_load_q <= ctx_load_d;
      pc_new_q <= pc_new_d;
      ccr_new_q <= ccr_new_d;
      exr_new_q <= exr_new_d;
      sp_new_q <= sp_new_d;
      err_set_q <= err_set_d;
      busy_q <= busy_d;
    end
  end

  // Every output is a flop or a plain fan-out of one, so no glitches leave the block
  assign busy = busy_q;
  assign int_ack = int_ack_q;
  assign mem_req = mem_req_q;
  assign mem_we = mem_we_q;
  assign mem_addr = mem_addr_q;
  assign mem_wdata = mem_wdata_q;
  assign ctx_load = ctx_load_q;
  assign pc_new = pc_new_q;
  assign ccr_new = ccr_new_q;
  assign exr_new = exr_new_q;
  assign sp_new = sp_new_q;
  assign exc_vector = vec_q;
  assign sleep_enter = sleep_enter_q;
  assign transfer_ctrl_err_set = err_set_q;
  assign dma_error_flag_set = err_set_q;
  assign dma_transfer_enable_clr = {CHANNELS{err_set_q}};

endmodule
`default_nettype wire

/* File: dv/exc_seq_chk_sva.sv */
// Concurrent checks on the exception sequencer ports
`timescale 1ns/1ns
`default_nettype none
module exc_seq_chk #(
  parameter int CHANNELS = 4
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [1:0] mode_sel,
  input wire logic insn_boundary,
  input wire logic bus_busy,
  input wire logic [31:0] sp,
  input wire logic [31:0] vector_base_reg,
  input wire logic sleep_exec,
  input wire logic software_standby_select,
  input wire logic sleep_exception_enable,
  input wire logic mem_ack,
  input wire logic [31:0] mem_rdata,
  input wire logic busy,
  input wire logic int_ack,
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [31:0] mem_addr,
  input wire logic ctx_load,
  input wire logic [31:0] pc_new,
  input wire logic [7:0] ccr_new,
  input wire logic [7:0] exr_new,
  input wire logic [7:0] exc_vector,
  input wire logic sleep_enter,
  input wire logic transfer_ctrl_err_set,
  input wire logic dma_error_flag_set,
  input wire logic [CHANNELS-1:0] dma_transfer_enable_clr
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  chk_start_gate: assert property (
    $rose(busy) |-> $past(insn_boundary) && !$past(bus_busy)) else $error("bad start");
  chk_err_flags: assert property (
    transfer_ctrl_err_set |-> dma_error_flag_set && (&dma_transfer_enable_clr) && $rose(busy))
    else $error("error flags wrong");
  chk_first_push: assert property (
    $rose(busy) |-> mem_req && mem_we && mem_addr == $past(sp) - 32'h4)
    else $error("first push wrong");
  chk_req_hold: assert property (
    mem_req && !mem_ack |=> mem_req && $stable(mem_addr) && $stable(mem_we))
    else $error("request dropped");
  chk_ctx_result: assert property (
    ctx_load |-> !busy && !mem_req && pc_new == $past(mem_rdata)
      && ccr_new[exc_seq_pkg::CCR_MASK_BIT]) else $error("context wrong");
  chk_trace_clear: assert property (
    ctx_load && mode_sel == 2'h2 |-> !exr_new[exc_seq_pkg::EXR_TRACE_BIT])
    else $error("trace bit set");
  chk_level_seven: assert property (
    ctx_load && mode_sel == 2'h2 && (exc_vector == exc_seq_pkg::VEC_ADDR_ERR
      || exc_vector == exc_seq_pkg::VEC_SLEEP) |-> exr_new[2:0] == 3'h7)
    else $error("level not seven");
  chk_vec_addr: assert property (
    mem_req && !mem_we |-> mem_addr == (exc_vector == exc_seq_pkg::VEC_ADDR_ERR ? 32'h0
      : vector_base_reg) + {22'h0, exc_vector, 2'h0}) else $error("vector address wrong");
  chk_sleep_gate: assert property (
    sleep_enter |-> $past(sleep_exec)
      && !(!$past(software_standby_select) && $past(sleep_exception_enable)))
    else $error("bad sleep entry");
  chk_int_ack: assert property (
    int_ack |-> $rose(busy)) else $error("ack without start");
  chk_done_bound: assert property (
    $rose(busy) |-> ##[1:60] ctx_load) else $error("sequence hung");
endmodule
bind cpu_exception_sequencer exc_seq_chk #(.CHANNELS(CHANNELS)) chk_i (.*);
`default_nettype wire

/* File: dv/exc_mem_model.sv */
// Memory model answering stack pushes and vector fetches
`timescale 1ns/1ns
`default_nettype none
module exc_mem_model (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [31:0] mem_addr,
  input wire logic slow,
  output logic mem_ack,
  output logic [31:0] mem_rdata
);
  logic [1:0] wait_q;
  // Off the ack cycle the data is inverted so stale reads never match
  assign mem_rdata = (mem_ack && !mem_we) ? mem_addr ^ 32'ha5a50000 : ~(mem_addr ^ 32'ha5a50000);
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      mem_ack <= 1'b0;
      wait_q <= 2'h0;
    end
    else if (mem_ack || !mem_req)
    begin
      mem_ack <= 1'b0;
      wait_q <= slow ? 2'h3 : 2'h0;
    end
    else if (wait_q != 2'h0)
      wait_q <= wait_q - 2'h1;
    else
      mem_ack <= 1'b1;
  end
endmodule
`default_nettype wire

/* File: dv/cpu_exception_sequencer_tb.sv */
// Randomised self-checking bench for the exception sequencer
`timescale 1ns/1ns
`default_nettype none
module cpu_exception_sequencer_tb;
  logic clk = 1'b0, arst_n = 1'b0, insn_boundary = 1'b0, bus_busy = 1'b0, cpu_has_bus = 1'b1;
  logic addr_err = 1'b0, trap_exec = 1'b0, sleep_exec = 1'b0, software_standby_select = 1'b0;
  logic sleep_exception_enable = 1'b1, undef_exec = 1'b0, delay_slot = 1'b0, slow = 1'b0;
  logic slot_multiword = 1'b0, slot_alters_pc = 1'b0, int_req = 1'b0;
  logic [1:0] mode_sel = 2'h0, trap_vec = 2'h0;
  logic [3:0] int_level = 4'h0, dma_transfer_enable_clr;
  logic [7:0] condition_code_reg = 8'h0, extended_control_reg = 8'h0, int_vector = 8'h0, ccr_new, exr_new, exc_vector;
  logic [31:0] pc = 32'h0, sp = 32'h0, vector_base_reg = 32'h0, mem_rdata, mem_addr, mem_wdata, pc_new, sp_new;
  logic mem_ack, busy, int_ack, mem_req, mem_we, ctx_load, sleep_enter;
  logic transfer_ctrl_err_set, dma_error_flag_set;
  int fail_count = 0, num_checks = 0;
  always #10 clk = ~clk;
  cpu_exception_sequencer #(.CHANNELS(4)) DUT (.*);
  exc_mem_model mem_i (.*);
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    chk_word({31'h0, got}, {31'h0, exp});
  endtask
  task automatic finish_test();
    $display("checks %0d failures %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask
  // Level 4'hf means the mask level is kept
  function automatic logic [7:0] exp_exr(input logic [7:0] e, input logic [3:0] lvl);
    if (mode_sel != 2'h2)
      return e;
    return {1'b0, e[6:3], lvl == 4'hf ? e[2:0] : lvl[2:0]};
  endfunction
  task automatic fire(input int k);
    case (k)
      0: addr_err = 1'b1;
      1: undef_exec = 1'b1;
      2: {delay_slot, slot_multiword} = 2'h3;
      3: {delay_slot, slot_alters_pc} = 2'h3;
      4: trap_exec = 1'b1;
      5: sleep_exec = 1'b1;
      default: int_req = 1'b1;
    endcase
    step(1);
    {addr_err, undef_exec, delay_slot, slot_multiword, slot_alters_pc} = 5'h0;
    {trap_exec, sleep_exec} = 2'h0;
  endtask
  task automatic take(input logic [7:0] vec, input logic [3:0] lvl, input logic ia,
      input logic reerr);
    logic [31:0] wa[$];
    logic [31:0] wd[$];
    logic [31:0] fa = 32'h0;
    int errs = 0;
    int acks = 0;
    insn_boundary = 1'b1;
    for (int i = 0; i < 80 && ctx_load !== 1'b1; i++)
    begin
      step(1);
      addr_err = reerr && i == 2;
      if (busy)
        insn_boundary = 1'b0;
      if (int_ack)
        int_req = 1'b0;
      errs += transfer_ctrl_err_set && dma_error_flag_set && &dma_transfer_enable_clr;
      acks += int_ack;
      if (mem_req && mem_ack && mem_we)
      begin
        wa.push_back(mem_addr);
        wd.push_back(mem_wdata);
      end
      if (mem_req && mem_ack && !mem_we)
        fa = mem_addr;
    end
    if (ctx_load !== 1'b1)
    begin
      chk_bit(ctx_load, 1'b1);
      finish_test();
    end
    chk_word(wa.size(), 2);
    chk_word(wa[0], sp - 32'h4);
    chk_word(wd[0], pc);
    chk_word(wa[1], sp - 32'h8);
    chk_word(wd[1], {16'h0, condition_code_reg, extended_control_reg});
    chk_word(fa, (vec == 8'h09 ? 32'h0 : vector_base_reg) + {22'h0, vec, 2'h0});
    chk_word(pc_new, fa ^ 32'ha5a50000);
    chk_word(sp_new, sp - 32'h8);
    chk_word({24'h0, ccr_new}, {24'h0, condition_code_reg | 8'h80});
    chk_word({24'h0, exr_new}, {24'h0, exp_exr(extended_control_reg, lvl)});
    chk_word(errs, {31'h0, vec == 8'h09});
    chk_word(acks, {31'h0, ia});
  endtask
  initial
  begin
    int k;
    logic [7:0] vec;
    logic [3:0] lvl;
    void'($urandom(42));
    step(6);
    arst_n = 1'b1;
    step(1);
    fire(0);
    bus_busy = 1'b1;
    insn_boundary = 1'b1;
    step(3);
    chk_bit(busy, 1'b0);
    bus_busy = 1'b0;
    take(8'h09, 4'h7, 1'b0, 1'b1);
    insn_boundary = 1'b1;
    step(4);
    chk_bit(busy, 1'b0);
    for (int r = 0; r < 48; r++)
    begin
      k = r % 8;
      mode_sel = r[3] ? 2'h2 : 2'h0;
      insn_boundary = 1'b0;
      pc = $urandom;
      sp = $urandom & 32'hfffffffc;
      vector_base_reg = $urandom & 32'hfffffc00;
      condition_code_reg = 8'($urandom) & 8'h7f;
      extended_control_reg = 8'($urandom) & 8'hfb;
      slow = 1'($urandom);
      trap_vec = 2'($urandom);
      int_vector = 8'h40 + 8'($urandom % 64);
      int_level = r[4] ? 4'h8 : 4'h5;
      vec = k == 0 ? 8'h09 : k == 1 ? 8'h04 : k < 4 ? 8'h06 : k == 4 ? 8'h0c + trap_vec
        : k == 5 ? 8'h0a : int_vector;
      lvl = (k == 0 || k == 5) ? 4'h7 : k != 6 ? 4'hf : r[4] ? 4'h7 : 4'h5;
      step(2);
      if (k == 7)
      begin
        condition_code_reg = condition_code_reg | 8'h80;
        int_level = 4'h0;
        int_req = 1'b1;
        software_standby_select = 1'b1;
        sleep_exec = 1'b1;
        step(1);
        sleep_exec = 1'b0;
        chk_bit(sleep_enter, 1'b1);
        insn_boundary = 1'b1;
        step(3);
        chk_bit(busy, 1'b0);
        {int_req, software_standby_select} = 2'h0;
      end
      else
      begin
        cpu_has_bus = k != 5;
        fire(k);
        if (k == 5)
        begin
          insn_boundary = 1'b1;
          step(3);
          chk_bit(busy, 1'b0);
          cpu_has_bus = 1'b1;
        end
        take(vec, lvl, k == 6, 1'b0);
      end
    end
    finish_test();
  end
endmodule
`default_nettype wire
